// ### common/timer_aux_pkg.sv
`default_nettype none
package timer_aux_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam logic [3:0] OFS_T1_CTRL = 4'h0;
    localparam logic [3:0] OFS_T3_CTRL = 4'h1;
    localparam logic [3:0] OFS_T4_CTRL = 4'h2;
    localparam logic [3:0] OFS_MEAS_CTRL = 4'h3;
    localparam logic [3:0] OFS_PIN_CTRL = 4'h4;
    localparam logic [3:0] OFS_IRQ0_CTRL = 4'h5;
    localparam logic [3:0] OFS_IRQ1_CTRL = 4'h6;
    localparam logic [3:0] OFS_PWM_LOW = 4'h7;
    localparam logic [3:0] OFS_PWM_HIGH = 4'h8;
    localparam logic [3:0] OFS_T4_COUNT = 4'h9;
    localparam logic [3:0] OFS_FLAGS = 4'hA;
    localparam logic [3:0] OFS_STATUS = 4'hB;
    localparam int TC_RUN = 2;
    localparam int TC_AUTOSTOP = 3;
    localparam int T4C_RUN = 1;
    localparam int T4C_EXT = 2;
    localparam int T4C_PWM = 3;
    localparam int MC_ENABLE = 2;
    localparam int PF_PINA_FN = 0;
    localparam int PF_GATE = 1;
    localparam int PF_EDGE_A = 2;
    localparam int PF_EDGE_B = 3;
    localparam int IC_SYNC = 0;
    localparam int IC_BOTH = 1;
    localparam int IC_RISE = 2;
    localparam int IC_ENABLE = 3;
    localparam logic [1:0] TGT_OSC = 2'h0;
    localparam logic [1:0] TGT_PIN_A = 2'h1;
    localparam logic [1:0] TGT_IRQ_A = 2'h2;
    localparam logic [1:0] PINA_SRC_T1 = 2'h1;
    localparam logic [1:0] PINA_SRC_T2 = 2'h2;
    localparam logic [3:0] CTRL_RST = 4'h0;
    localparam logic [7:0] RELOAD_RST = 8'h00;
    typedef struct packed {
        logic o;
        logic oe;
    } pin_drive_t;
    typedef struct packed {
        logic t4;
        logic t3;
        logic t2;
        logic t1;
    } tflags_t;
    typedef enum {M_IDLE, M_ARMED, M_COUNT, M_DONE} meas_state_t;
endpackage
`default_nettype wire

// ### logic/timer_aux.sv
// The implementer's own choices: the address map and the strobed register port.
`timescale 1ns/1ps
`default_nettype none

module pin_sync
(
    input wire logic MCLK,
    input wire logic RESET,
    input wire logic CE,
    input wire logic PIN,
    output logic level,
    output logic rise,
    output logic fall
);
    logic s1;
    logic s2;
    logic s3;
    // first stage feeds only the second
    always_ff @(posedge MCLK)
    begin
        if (RESET)
        begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
        end
        else if (CE)
        begin
            s1 <= PIN;
            s2 <= s1;
            s3 <= s2;
        end
    end
    assign level = s2;
    assign rise = s2 & ~s3;
    assign fall = ~s2 & s3;
endmodule

////////////////////////////////////////////////////////////////////////////////

module timer_aux
(
    input wire logic MCLK,
    input wire logic RESET,
    input wire logic CE,
    input wire logic [timer_aux_pkg::ADDR_W-1:0] ADDR,
    input wire logic [timer_aux_pkg::DATA_W-1:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [timer_aux_pkg::DATA_W-1:0] RDATA,
    input wire logic EXT_IRQ_PIN_A,
    input wire logic EXT_IRQ_PIN_B,
    input wire logic TIMER_PIN_A_I,
    input wire logic TIMER_PIN_B_I,
    input wire logic OSC_DIV16,
    input wire logic T1_UNDERFLOW,
    input wire logic T2_UNDERFLOW,
    input wire logic T3_UNDERFLOW,
    input wire logic T3_PIN_SOURCE,
    input wire logic [1:0] PIN_A_OUT_SRC,
    input wire logic T4_COUNT_PULSE,
    input wire logic T4_HALF_PULSE,
    input wire timer_aux_pkg::tflags_t FLAG_ACK,
    output timer_aux_pkg::tflags_t IRQ_FLAGS,
    output logic T1_COUNT_ENABLE,
    output logic T3_COUNT_ENABLE,
    output logic T1_PIN_COUNT,
    output logic T3_PIN_COUNT,
    output logic T4_UNDERFLOW,
    output logic PWM_WAVE,
    output timer_aux_pkg::pin_drive_t TIMER_PIN_A,
    output timer_aux_pkg::pin_drive_t TIMER_PIN_B
);
    import timer_aux_pkg::*;

    logic [3:0] timer1_ctrl;
    logic [3:0] timer3_ctrl;
    logic [3:0] timer4_ctrl;
    logic [3:0] measure_ctrl;
    logic [3:0] pin_function_ctrl;
    logic [3:0] irq0_ctrl;
    logic [3:0] irq1_ctrl;
    logic [7:0] pwm_low_reload;
    logic [7:0] pwm_high_reload;
    logic [7:0] t4_cnt;
    logic ext_pend;
    logic sync1;
    logic sync3;
    logic gate_on;
    logic pina_toggle;
    logic meas_pol_low;
    meas_state_t mstate;
    tflags_t flags;
    logic ia_lvl, ia_rise, ia_fall;
    logic ib_lvl, ib_rise, ib_fall;
    logic pa_lvl, pa_rise, pa_fall;
    logic pb_lvl, pb_rise, pb_fall;
    logic osc_lvl, osc_d;
    logic irq0_valid;
    logic irq1_valid;
    logic wr_t4;
    logic t4_running;
    logic t4_uf;
    logic meas_start_edge;
    logic meas_stop_edge;
    logic meas_done_ev;
    logic pwm_enabled;
    logic [1:0] mcode;

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    pin_sync u_ia (.MCLK(MCLK), .RESET(RESET), .CE(CE), .PIN(EXT_IRQ_PIN_A),
        .level(ia_lvl), .rise(ia_rise), .fall(ia_fall));
    pin_sync u_ib (.MCLK(MCLK), .RESET(RESET), .CE(CE), .PIN(EXT_IRQ_PIN_B),
        .level(ib_lvl), .rise(ib_rise), .fall(ib_fall));
    pin_sync u_pa (.MCLK(MCLK), .RESET(RESET), .CE(CE), .PIN(TIMER_PIN_A_I),
        .level(pa_lvl), .rise(pa_rise), .fall(pa_fall));
    pin_sync u_pb (.MCLK(MCLK), .RESET(RESET), .CE(CE), .PIN(TIMER_PIN_B_I),
        .level(pb_lvl), .rise(pb_rise), .fall(pb_fall));

    assign irq0_valid = irq0_ctrl[IC_ENABLE] & (irq0_ctrl[IC_BOTH] ? (ia_rise | ia_fall)
        : (irq0_ctrl[IC_RISE] ? ia_rise : ia_fall));
    assign irq1_valid = irq1_ctrl[IC_ENABLE] & (irq1_ctrl[IC_BOTH] ? (ib_rise | ib_fall)
        : (irq1_ctrl[IC_RISE] ? ib_rise : ib_fall));

    always_ff @(posedge MCLK)
    begin
        if (RESET)
            osc_d <= 1'b0;
        else if (CE)
            osc_d <= osc_lvl;
    end
    assign osc_lvl = OSC_DIV16;

    ////////////////////////////////////////////////////////////////////////////
    // control registers; hardware disarm of auto-stop loses to a same-cycle write
    always_ff @(posedge MCLK)
    begin
        if (RESET)
        begin
            timer1_ctrl <= CTRL_RST;
            timer3_ctrl <= CTRL_RST;
            timer4_ctrl <= CTRL_RST;
            measure_ctrl <= CTRL_RST;
            pin_function_ctrl <= CTRL_RST;
            irq0_ctrl <= CTRL_RST;
            irq1_ctrl <= CTRL_RST;
            pwm_low_reload <= RELOAD_RST;
            pwm_high_reload <= RELOAD_RST;
        end
        else if (CE)
        begin
            if (irq0_ctrl[IC_SYNC] && timer1_ctrl[TC_AUTOSTOP] && T1_UNDERFLOW)
                timer1_ctrl[TC_AUTOSTOP] <= 1'b0;
            if (irq1_ctrl[IC_SYNC] && timer3_ctrl[TC_AUTOSTOP] && T3_UNDERFLOW)
                timer3_ctrl[TC_AUTOSTOP] <= 1'b0;
            if (WR)
            begin
                case (ADDR)
                    OFS_T1_CTRL: timer1_ctrl <= WDATA[3:0];
                    OFS_T3_CTRL: timer3_ctrl <= WDATA[3:0];
                    OFS_T4_CTRL: timer4_ctrl <= WDATA[3:0];
                    OFS_MEAS_CTRL: measure_ctrl <= WDATA[3:0];
                    OFS_PIN_CTRL: pin_function_ctrl <= WDATA[3:0];
                    OFS_IRQ0_CTRL: irq0_ctrl <= WDATA[3:0];
                    OFS_IRQ1_CTRL: irq1_ctrl <= WDATA[3:0];
                    OFS_PWM_LOW: pwm_low_reload <= WDATA;
                    OFS_T4_COUNT: pwm_low_reload <= WDATA;
                    OFS_PWM_HIGH: pwm_high_reload <= WDATA;
                    default: ;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // start gates
    always_ff @(posedge MCLK)
    begin
        if (RESET)
        begin
            sync1 <= 1'b0;
            sync3 <= 1'b0;
        end
        else if (CE)
        begin
            if (!irq0_ctrl[IC_SYNC])
                sync1 <= 1'b0;
            else if (timer1_ctrl[TC_AUTOSTOP] && T1_UNDERFLOW)
                sync1 <= 1'b0;
            else if (irq0_valid)
                sync1 <= 1'b1;
            if (!irq1_ctrl[IC_SYNC])
                sync3 <= 1'b0;
            else if (timer3_ctrl[TC_AUTOSTOP] && T3_UNDERFLOW)
                sync3 <= 1'b0;
            else if (irq1_valid)
                sync3 <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // measurement circuit; a target edge before timer 1 runs is not counted
    assign mcode = measure_ctrl[1:0];

    always_comb
    begin
        meas_start_edge = 1'b0;
        meas_stop_edge = 1'b0;
        case (mcode)
            TGT_OSC:
            begin
                meas_start_edge = ~osc_lvl & osc_d;
                meas_stop_edge = ~osc_lvl & osc_d;
            end
            TGT_PIN_A:
            begin
                meas_start_edge = pin_function_ctrl[PF_EDGE_A] ? pa_rise : pa_fall;
                meas_stop_edge = meas_start_edge;
            end
            TGT_IRQ_A:
            begin
                if (irq0_ctrl[IC_BOTH])
                begin
                    meas_start_edge = meas_pol_low ? ia_fall : ia_rise;
                    meas_stop_edge = meas_pol_low ? ia_rise : ia_fall;
                end
                else
                begin
                    meas_start_edge = irq0_ctrl[IC_RISE] ? ia_rise : ia_fall;
                    meas_stop_edge = meas_start_edge;
                end
            end
            default: ;
        endcase
    end

    assign meas_done_ev = (mstate == M_COUNT) && meas_stop_edge;

    always_ff @(posedge MCLK)
    begin
        if (RESET)
        begin
            mstate <= M_IDLE;
            meas_pol_low <= 1'b0;
        end
        else if (CE)
        begin
            if (!measure_ctrl[MC_ENABLE])
                mstate <= M_IDLE;
            else
            begin
                case (mstate)
                    M_IDLE:
                    begin
                        if (timer1_ctrl[TC_RUN])
                        begin
                            mstate <= M_ARMED;
                            meas_pol_low <= ia_lvl;
                        end
                    end
                    M_ARMED:
                    begin
                        if (meas_start_edge)
                            mstate <= M_COUNT;
                    end
                    M_COUNT:
                    begin
                        if (meas_stop_edge)
                            mstate <= M_DONE;
                    end
                    M_DONE: ;
                    default: mstate <= M_IDLE;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // timer 4 and pwm
    assign wr_t4 = WR && (ADDR == OFS_T4_COUNT);
    // high interval runs out before stopping
    assign t4_running = timer4_ctrl[T4C_RUN] | (timer4_ctrl[T4C_PWM] & PWM_WAVE);
    assign t4_uf = t4_running && !ext_pend && T4_COUNT_PULSE && (t4_cnt == 8'h00) && !wr_t4;

    always_ff @(posedge MCLK)
    begin
        if (RESET)
        begin
            t4_cnt <= RELOAD_RST;
            PWM_WAVE <= 1'b0;
            ext_pend <= 1'b0;
        end
        else if (CE)
        begin
            if (wr_t4)
            begin
                t4_cnt <= WDATA;
                PWM_WAVE <= 1'b0;
                ext_pend <= 1'b0;
            end
            else if (ext_pend)
            begin
                if (T4_HALF_PULSE)
                begin
                    ext_pend <= 1'b0;
                    PWM_WAVE <= 1'b0;
                end
            end
            else if (t4_uf)
            begin
                if (timer4_ctrl[T4C_PWM] && !PWM_WAVE)
                begin
                    t4_cnt <= pwm_high_reload;
                    PWM_WAVE <= 1'b1;
                end
                else
                begin
                    t4_cnt <= pwm_low_reload;
                    // hold high for half a period
                    if (timer4_ctrl[T4C_PWM] && timer4_ctrl[T4C_EXT])
                        ext_pend <= 1'b1;
                    else
                        PWM_WAVE <= 1'b0;
                end
            end
            else if (t4_running && T4_COUNT_PULSE)
                t4_cnt <= t4_cnt - 8'h01;
            if (!timer4_ctrl[T4C_PWM] && !wr_t4)
            begin
                PWM_WAVE <= 1'b0;
                ext_pend <= 1'b0;
            end
        end
    end

    always_ff @(posedge MCLK)
    begin
        if (RESET)
            gate_on <= 1'b0;
        else if (CE)
        begin
            if (!pin_function_ctrl[PF_GATE] || !timer3_ctrl[TC_RUN])
                gate_on <= 1'b0;
            else if (T3_UNDERFLOW)
                gate_on <= ~gate_on;
        end
    end
    assign pwm_enabled = ~(pin_function_ctrl[PF_GATE] & timer3_ctrl[TC_RUN]) | gate_on;

    ////////////////////////////////////////////////////////////////////////////
    // flags: a set beats a same-cycle clear
    always_ff @(posedge MCLK)
    begin
        if (RESET)
            flags <= '0;
        else if (CE)
        begin
            // set on underflow (t1 while measuring: on measurement done), clear on ack
            flags.t1 <= (measure_ctrl[MC_ENABLE] ? meas_done_ev : T1_UNDERFLOW)
                | (flags.t1 & ~FLAG_ACK.t1 & ~(WR && ADDR == OFS_FLAGS && WDATA[0]));
            flags.t2 <= T2_UNDERFLOW
                | (flags.t2 & ~FLAG_ACK.t2 & ~(WR && ADDR == OFS_FLAGS && WDATA[1]));
            flags.t3 <= T3_UNDERFLOW
                | (flags.t3 & ~FLAG_ACK.t3 & ~(WR && ADDR == OFS_FLAGS && WDATA[2]));
            flags.t4 <= t4_uf
                | (flags.t4 & ~FLAG_ACK.t4 & ~(WR && ADDR == OFS_FLAGS && WDATA[3]));
        end
    end
    assign IRQ_FLAGS = flags;

    ////////////////////////////////////////////////////////////////////////////
    // timer pins and gates
    always_ff @(posedge MCLK)
    begin
        if (RESET)
        begin
            pina_toggle <= 1'b0;
            TIMER_PIN_A <= '0;
            TIMER_PIN_B <= '0;
            T1_COUNT_ENABLE <= 1'b0;
            T3_COUNT_ENABLE <= 1'b0;
            T1_PIN_COUNT <= 1'b0;
            T3_PIN_COUNT <= 1'b0;
            T4_UNDERFLOW <= 1'b0;
        end
        else if (CE)
        begin
            if ((PIN_A_OUT_SRC == PINA_SRC_T1 && T1_UNDERFLOW)
                || (PIN_A_OUT_SRC == PINA_SRC_T2 && T2_UNDERFLOW))
                pina_toggle <= ~pina_toggle;
            TIMER_PIN_A.o <= pina_toggle;
            TIMER_PIN_A.oe <= pin_function_ctrl[PF_PINA_FN]
                & (PIN_A_OUT_SRC == PINA_SRC_T1 || PIN_A_OUT_SRC == PINA_SRC_T2);
            TIMER_PIN_B.o <= PWM_WAVE & pwm_enabled;
            TIMER_PIN_B.oe <= timer4_ctrl[T4C_PWM] & ~T3_PIN_SOURCE;
            T1_PIN_COUNT <= pin_function_ctrl[PF_EDGE_A] ? pa_rise : pa_fall;
            T3_PIN_COUNT <= T3_PIN_SOURCE & (pin_function_ctrl[PF_EDGE_B] ? pb_rise : pb_fall);
            T1_COUNT_ENABLE <= timer1_ctrl[TC_RUN] & (~irq0_ctrl[IC_SYNC] | sync1)
                & (~measure_ctrl[MC_ENABLE] | (mstate == M_COUNT));
            T3_COUNT_ENABLE <= timer3_ctrl[TC_RUN] & (~irq1_ctrl[IC_SYNC] | sync3);
            T4_UNDERFLOW <= t4_uf;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read port
    always_ff @(posedge MCLK)
    begin
        if (RESET)
            RDATA <= '0;
        else if (CE)
        begin
            RDATA <= '0;
            if (RD)
            begin
                case (ADDR)
                    OFS_T1_CTRL: RDATA <= {4'h0, timer1_ctrl};
                    OFS_T3_CTRL: RDATA <= {4'h0, timer3_ctrl};
                    OFS_T4_CTRL: RDATA <= {4'h0, timer4_ctrl};
                    OFS_MEAS_CTRL: RDATA <= {4'h0, measure_ctrl};
                    OFS_PIN_CTRL: RDATA <= {4'h0, pin_function_ctrl};
                    OFS_IRQ0_CTRL: RDATA <= {4'h0, irq0_ctrl};
                    OFS_IRQ1_CTRL: RDATA <= {4'h0, irq1_ctrl};
                    OFS_PWM_LOW: RDATA <= pwm_low_reload;
                    OFS_PWM_HIGH: RDATA <= pwm_high_reload;
                    OFS_T4_COUNT: RDATA <= t4_cnt;
                    OFS_FLAGS: RDATA <= {4'h0, flags};
                    OFS_STATUS: RDATA <= {1'b0, gate_on, ext_pend, PWM_WAVE,
                        mstate == M_DONE, mstate == M_COUNT, sync3, sync1};
                    default: RDATA <= '0;
                endcase
            end
        end
    end
endmodule

`default_nettype wire

// ### sim/timer_aux_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module timer_aux_monitor
(
    input wire logic MCLK,
    input wire logic RESET,
    input wire logic WR,
    input wire logic T2_UNDERFLOW,
    input wire logic T3_UNDERFLOW,
    input wire logic T3_PIN_SOURCE,
    input wire logic T4_COUNT_PULSE,
    input wire logic T4_HALF_PULSE,
    input wire timer_aux_pkg::tflags_t FLAG_ACK,
    input wire timer_aux_pkg::tflags_t IRQ_FLAGS,
    input wire logic T3_COUNT_ENABLE,
    input wire logic T3_PIN_COUNT,
    input wire logic T4_UNDERFLOW,
    input wire logic PWM_WAVE,
    input wire timer_aux_pkg::pin_drive_t TIMER_PIN_B
);
    import timer_aux_pkg::*;
    default clocking @(posedge MCLK);
    endclocking
    default disable iff (RESET);
    a_reset_clear: assert property
        ($fell(RESET) |-> IRQ_FLAGS == 4'h0 && !PWM_WAVE && !T3_COUNT_ENABLE)
        else $error("state not cleared by reset");
    a_flag_set: assert property (T2_UNDERFLOW |=> IRQ_FLAGS.t2)
        else $error("flag not set by underflow");
    a_flag_clear: assert property (FLAG_ACK.t3 && !T3_UNDERFLOW |=> !IRQ_FLAGS.t3)
        else $error("flag not cleared by ack");
    a_t4_cause: assert property (T4_UNDERFLOW |-> $past(T4_COUNT_PULSE))
        else $error("underflow without count pulse");
    a_pinb_input: assert property (T3_PIN_SOURCE |=> !TIMER_PIN_B.oe)
        else $error("pin b driven while an input");
    a_count_pulse: assert property (T3_PIN_COUNT |=> !T3_PIN_COUNT)
        else $error("pin count pulse too long");
    // gate only drops on a write or an underflow, never by itself
    a_gate_hold: assert property ($fell(T3_COUNT_ENABLE) |-> $past(WR)
        || $past(WR, 2) || $past(T3_UNDERFLOW) || $past(T3_UNDERFLOW, 2))
        else $error("start gate dropped without cause");
    a_pwm_cause: assert property ($changed(PWM_WAVE) |-> T4_UNDERFLOW
        || $past(T4_UNDERFLOW) || $past(T4_HALF_PULSE) || $past(T4_HALF_PULSE, 2)
        || $past(WR) || $past(WR, 2) || $past(T3_UNDERFLOW))
        else $error("pwm changed without cause");
    c_t4_uf: cover property (T4_UNDERFLOW);
    c_gate: cover property ($rose(T3_COUNT_ENABLE));
    c_pin: cover property (T3_PIN_COUNT);
endmodule
bind timer_aux timer_aux_monitor u_mon
(
    .MCLK, .RESET, .WR, .T2_UNDERFLOW, .T3_UNDERFLOW, .T3_PIN_SOURCE, .T4_COUNT_PULSE,
    .T4_HALF_PULSE, .FLAG_ACK, .IRQ_FLAGS, .T3_COUNT_ENABLE, .T3_PIN_COUNT,
    .T4_UNDERFLOW, .PWM_WAVE, .TIMER_PIN_B
);
`default_nettype wire

// ### sim/pin_source.sv
`timescale 1ns/1ps
`default_nettype none
// outside pulse sources; the delay keeps edges unrelated to the clock
module pin_source
(
    input wire logic [3:0] req,
    output logic [3:0] pin
);
    // pins idle low from time zero, not unknown until the first request
    initial pin = 4'h0;
    always @(req)
        pin <= #7 req;
endmodule
`default_nettype wire

// ### sim/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import timer_aux_pkg::*;
    logic MCLK = 0, RESET = 1, CE = 1, WR = 0, RD = 0, OSC_DIV16 = 0, sel = 0, src_on = 0;
    logic T1_UNDERFLOW = 0, T2_UNDERFLOW = 0, T3_UNDERFLOW = 0, T3_PIN_SOURCE = 0;
    logic T4_COUNT_PULSE = 0, T4_HALF_PULSE = 0, en;
    logic T1_COUNT_ENABLE, T3_COUNT_ENABLE, T1_PIN_COUNT, T3_PIN_COUNT, T4_UNDERFLOW, PWM_WAVE;
    logic [3:0] ADDR = 0, req = 0, pins;
    logic [7:0] WDATA = 0, RDATA, lo, hi;
    logic [1:0] PIN_A_OUT_SRC = 0, ph = 0;
    logic [31:0] seed = 33;
    tflags_t FLAG_ACK = 0, IRQ_FLAGS;
    pin_drive_t TIMER_PIN_A, TIMER_PIN_B;
    int fail_count = 0, n_tests = 0, cyc = 0, ef = 0, n = 0, h, l, cnt;
    assign en = sel ? T3_COUNT_ENABLE : T1_COUNT_ENABLE;
    always #12.5 MCLK = ~MCLK;
    pin_source u_src (.req(req), .pin(pins));
    timer_aux u_dut
    (
        .MCLK, .RESET, .CE, .ADDR, .WDATA, .WR, .RD, .RDATA, .EXT_IRQ_PIN_A(pins[0]),
        .EXT_IRQ_PIN_B(pins[1]), .TIMER_PIN_A_I(pins[2]), .TIMER_PIN_B_I(pins[3]), .OSC_DIV16,
        .T1_UNDERFLOW, .T2_UNDERFLOW, .T3_UNDERFLOW, .T3_PIN_SOURCE, .PIN_A_OUT_SRC,
        .T4_COUNT_PULSE, .T4_HALF_PULSE, .FLAG_ACK, .IRQ_FLAGS, .T1_COUNT_ENABLE,
        .T3_COUNT_ENABLE, .T1_PIN_COUNT, .T3_PIN_COUNT, .T4_UNDERFLOW, .PWM_WAVE,
        .TIMER_PIN_A, .TIMER_PIN_B
    );
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic final_report();
        if (fail_count == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // a gap cycle after each strobe so no strobe is set twice in one step
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'h1;
        @(posedge MCLK);
        WR <= 1'h0;
        @(posedge MCLK);
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        ADDR <= a;
        RD <= 1'h1;
        @(posedge MCLK);
        RD <= 1'h0;
        #1 chk(RDATA, e);
        @(posedge MCLK);
    endtask
    task automatic wedge(input logic v, output int c);
        c = 0;
        while (PWM_WAVE !== v && c < 300)
        begin
            @(negedge MCLK);
            c++;
        end
    endtask
    task automatic gate(input logic [3:0] tc, input logic [3:0] ic, input int k);
        wr(ic, 8'h0D);
        wr(tc, k ? 8'h0C : 8'h04);
        sel = k[0];
        repeat (4) @(negedge MCLK);
        chk(en, 8'h00);
        req[k] = 1'h1;
        n = 0;
        while (en !== 1'h1 && n < 20)
        begin
            @(negedge MCLK);
            n++;
        end
        chk(en, 8'h01);
        @(posedge MCLK);
        {T3_UNDERFLOW, T1_UNDERFLOW} <= k ? 2'h2 : 2'h1;
        @(posedge MCLK);
        {T3_UNDERFLOW, T1_UNDERFLOW} <= 2'h0;
        repeat (3) @(negedge MCLK);
        chk(en, k ? 8'h00 : 8'h01);
        req[k] = 1'h0;
        @(posedge MCLK);
        rd(tc, 8'h04);
        wr(ic, 8'h00);
        wr(tc, 8'h00);
    endtask
    // count source: count pulse then half pulse two cycles later, period 4
    always @(posedge MCLK)
    begin
        cyc <= cyc + 1;
        ph <= ph + 2'h1;
        T4_COUNT_PULSE <= src_on && ph == 2'h3;
        T4_HALF_PULSE <= src_on && ph == 2'h1;
        if (cyc == 5000)
        begin
            fail_count++;
            final_report();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (20) @(posedge MCLK);
        RESET <= 1'h0;
        @(posedge MCLK);
        rd(OFS_FLAGS, 8'h00);
        rd(4'hF, 8'h00);
        repeat (200)
        begin
            @(posedge MCLK);
            ef = (ef & ~n[7:4]) | n[2:0];
            n = xs();
            {T3_UNDERFLOW, T2_UNDERFLOW, T1_UNDERFLOW} <= n[2:0];
            FLAG_ACK <= n[7:4];
            @(negedge MCLK);
            chk(IRQ_FLAGS, ef);
        end
        {T3_UNDERFLOW, T2_UNDERFLOW, T1_UNDERFLOW} <= 3'h0;
        FLAG_ACK <= '0;
        @(posedge MCLK);
        gate(OFS_T1_CTRL, OFS_IRQ0_CTRL, 0);
        gate(OFS_T3_CTRL, OFS_IRQ1_CTRL, 1);
        // pulse width: pin low at start, so the high pulse is measured
        wr(OFS_FLAGS, 8'h0F);
        wr(OFS_IRQ0_CTRL, 8'h0A);
        wr(OFS_MEAS_CTRL, 8'h06);
        wr(OFS_T1_CTRL, 8'h04);
        sel = 1'h0;
        cnt = 0;
        for (int i = 0; i < 30; i++)
        begin
            @(negedge MCLK);
            req[0] = i > 4 && i < 17;
            cnt += en;
        end
        chk(cnt, 8'h0C);
        chk(IRQ_FLAGS, 8'h01);
        rd(OFS_STATUS, 8'h08);
        wr(OFS_MEAS_CTRL, 8'h00);
        wr(OFS_T1_CTRL, 8'h00);
        wr(OFS_IRQ0_CTRL, 8'h00);
        src_on <= 1'h1;
        for (int e = 0; e < 2; e++)
        begin
            n = xs();
            lo = 8'h01 + n[1:0];
            hi = 8'h01 + n[3:2];
            wr(OFS_PWM_LOW, lo);
            wr(OFS_PWM_HIGH, hi);
            wr(OFS_T4_COUNT, lo);
            wr(OFS_T4_CTRL, e ? 8'h0E : 8'h0A);
            wedge(0, n);
            wedge(1, n);
            wedge(0, h);
            wedge(1, l);
            // pin b is registered one cycle behind the wave
            @(negedge MCLK);
            chk(TIMER_PIN_B.oe, 8'h01);
            chk(TIMER_PIN_B.o, PWM_WAVE);
            // stretch moves the falling edge by half a period; the period stays
            chk(h, e ? (hi + 1) * 4 + 2 : (hi + 1) * 4);
            chk(e ? h + l : l, e ? (lo + hi + 2) * 4 : (lo + 1) * 4);
            wr(OFS_T3_CTRL, 8'h04);
            wr(OFS_PIN_CTRL, 8'h02);
            wedge(0, n);
            wedge(1, n);
            @(negedge MCLK);
            chk(TIMER_PIN_B.o, 8'h00);
            @(posedge MCLK);
            T3_UNDERFLOW <= 1'h1;
            @(posedge MCLK);
            T3_UNDERFLOW <= 1'h0;
            repeat (2) @(negedge MCLK);
            chk(TIMER_PIN_B.o, 8'h01);
            wr(OFS_T3_CTRL, 8'h00);
            wr(OFS_PIN_CTRL, 8'h00);
            wr(OFS_T4_CTRL, 8'h00);
            repeat (60) @(posedge MCLK);
        end
        src_on <= 1'h0;
        // pwm selected, so only the count input keeps pin b undriven
        wr(OFS_T4_CTRL, 8'h08);
        wr(OFS_PIN_CTRL, 8'h0D);
        wr(OFS_T3_CTRL, 8'h04);
        T3_PIN_SOURCE <= 1'h1;
        PIN_A_OUT_SRC <= PINA_SRC_T1;
        cnt = 0;
        h = 0;
        for (int i = 0; i < 20; i++)
        begin
            @(negedge MCLK);
            req[3:2] = i < 9 ? 2'h3 : 2'h0;
            cnt += T3_PIN_COUNT;
            h += T1_PIN_COUNT;
        end
        chk(cnt, 8'h01);
        chk(h, 8'h01);
        chk(TIMER_PIN_B.oe, 8'h00);
        @(posedge MCLK);
        T1_UNDERFLOW <= 1'h1;
        @(posedge MCLK);
        T1_UNDERFLOW <= 1'h0;
        repeat (2) @(negedge MCLK);
        chk({TIMER_PIN_A.oe, TIMER_PIN_A.o}, 8'h03);
        final_report();
    end
endmodule
`default_nettype wire
